// *** hw/sfdc_top.sv ***
// Purpose: configuration registers and fault detectors for supply inputs two and three
// Assumes: serial management engine outside presents decoded byte accesses
// Notes: unused register bits read as zero and ignore writes
module sfdc_top #(
  parameter int p_gf50_cycles = sfdc_pkg::SFDC_GF50_CYC,
  parameter int p_gf75_cycles = sfdc_pkg::SFDC_GF75_CYC,
  parameter int p_gf100_cycles = sfdc_pkg::SFDC_GF100_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // measured levels
  input wire logic [7:0] i_second_supply_input,
  input wire logic [7:0] i_third_supply_input,
  // third input settings held elsewhere
  input wire logic [2:0] i_supply3_glitch_filter_code,
  input wire logic [1:0] i_supply3_fault_type_code,
  input wire logic [1:0] i_supply3_range_code,
  // results
  output sfdc_pkg::sfdc_range_e o_supply2_range,
  output sfdc_pkg::sfdc_range_e o_supply3_range,
  output logic o_supply2_over,
  output logic o_supply2_under,
  output logic o_supply2_fault,
  output logic o_supply3_over,
  output logic o_supply3_under,
  output logic o_supply3_fault
);
  import sfdc_pkg::*;

  logic [7:0] s2_over_threshold_code;
  logic [4:0] s2_over_hysteresis_code;
  logic [7:0] s2_under_threshold_code;
  logic [4:0] s2_under_hysteresis_code;
  logic [2:0] s2_glitch_filter_code;
  logic [1:0] s2_fault_type_code;
  logic [1:0] s2_range_code;
  logic [7:0] s3_over_threshold_code;
  logic [4:0] s3_over_hysteresis_code;
  logic [7:0] s3_under_threshold_code;
  logic [4:0] s3_under_hysteresis_code;
  logic [7:0] next_rdata;

  // ----------------------------------------
  // range decode
  // ----------------------------------------
  function automatic sfdc_range_e range_decode(input logic [1:0] code);
    sfdc_range_e r;
    case (code)
      2'b00: r = SFDC_RANGE_MID;
      2'b01: r = SFDC_RANGE_LOW;
      default: r = SFDC_RANGE_ULTRALOW;
    endcase
    return r;
  endfunction

  assign o_supply2_range = range_decode(s2_range_code);
  assign o_supply3_range = range_decode(i_supply3_range_code);

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  function automatic logic wr_hit(input logic [7:0] addr);
    return i_reg_wr && (i_reg_addr == addr);
  endfunction

  // ----------------------------------------
  // second input registers
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s2_over_threshold_code <= SFDC_RST_OVER_TH;
    end else if (wr_hit(SFDC_S2_OVER_TH)) begin
      s2_over_threshold_code <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s2_over_hysteresis_code <= SFDC_RST_HY;
    end else if (wr_hit(SFDC_S2_OVER_HY)) begin
      s2_over_hysteresis_code <= i_reg_wdata[SFDC_HY_W-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s2_under_threshold_code <= SFDC_RST_UNDER_TH;
    end else if (wr_hit(SFDC_S2_UNDER_TH)) begin
      s2_under_threshold_code <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s2_under_hysteresis_code <= SFDC_RST_HY;
    end else if (wr_hit(SFDC_S2_UNDER_HY)) begin
      s2_under_hysteresis_code <= i_reg_wdata[SFDC_HY_W-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s2_glitch_filter_code <= SFDC_RST_GF;
      s2_fault_type_code <= SFDC_RST_FLT;
    end else if (wr_hit(SFDC_S2_CFG)) begin
      s2_glitch_filter_code <= i_reg_wdata[SFDC_GF_LSB +: SFDC_GF_W];
      s2_fault_type_code <= i_reg_wdata[SFDC_FLT_LSB +: SFDC_FLT_W];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s2_range_code <= SFDC_RST_SEL;
    end else if (wr_hit(SFDC_S2_SEL)) begin
      s2_range_code <= i_reg_wdata[SFDC_SEL_W-1:0];
    end
  end

  // ----------------------------------------
  // third input registers
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s3_over_threshold_code <= SFDC_RST_OVER_TH;
    end else if (wr_hit(SFDC_S3_OVER_TH)) begin
      s3_over_threshold_code <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s3_over_hysteresis_code <= SFDC_RST_HY;
    end else if (wr_hit(SFDC_S3_OVER_HY)) begin
      s3_over_hysteresis_code <= i_reg_wdata[SFDC_HY_W-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s3_under_threshold_code <= SFDC_RST_UNDER_TH;
    end else if (wr_hit(SFDC_S3_UNDER_TH)) begin
      s3_under_threshold_code <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s3_under_hysteresis_code <= SFDC_RST_HY;
    end else if (wr_hit(SFDC_S3_UNDER_HY)) begin
      s3_under_hysteresis_code <= i_reg_wdata[SFDC_HY_W-1:0];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    case (i_reg_addr)
      SFDC_S2_OVER_TH: next_rdata = s2_over_threshold_code;
      SFDC_S2_OVER_HY: next_rdata = {3'h0, s2_over_hysteresis_code};
      SFDC_S2_UNDER_TH: next_rdata = s2_under_threshold_code;
      SFDC_S2_UNDER_HY: next_rdata = {3'h0, s2_under_hysteresis_code};
      SFDC_S2_CFG: next_rdata = {3'h0, s2_glitch_filter_code, s2_fault_type_code};
      SFDC_S2_SEL: next_rdata = {6'h00, s2_range_code};
      SFDC_S3_OVER_TH: next_rdata = s3_over_threshold_code;
      SFDC_S3_OVER_HY: next_rdata = {3'h0, s3_over_hysteresis_code};
      SFDC_S3_UNDER_TH: next_rdata = s3_under_threshold_code;
      SFDC_S3_UNDER_HY: next_rdata = {3'h0, s3_under_hysteresis_code};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // detectors
  // ----------------------------------------
  sfdc_detector #(
    .p_gf50_cycles(p_gf50_cycles),
    .p_gf75_cycles(p_gf75_cycles),
    .p_gf100_cycles(p_gf100_cycles)
  ) u_det2 (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_level(i_second_supply_input),
    .i_over_th(s2_over_threshold_code),
    .i_over_hy(s2_over_hysteresis_code),
    .i_under_th(s2_under_threshold_code),
    .i_under_hy(s2_under_hysteresis_code),
    .i_gf_code(s2_glitch_filter_code),
    .i_fault_type(s2_fault_type_code),
    .o_over(o_supply2_over),
    .o_under(o_supply2_under),
    .o_fault(o_supply2_fault)
  );

  sfdc_detector #(
    .p_gf50_cycles(p_gf50_cycles),
    .p_gf75_cycles(p_gf75_cycles),
    .p_gf100_cycles(p_gf100_cycles)
  ) u_det3 (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_level(i_third_supply_input),
    .i_over_th(s3_over_threshold_code),
    .i_over_hy(s3_over_hysteresis_code),
    .i_under_th(s3_under_threshold_code),
    .i_under_hy(s3_under_hysteresis_code),
    .i_gf_code(i_supply3_glitch_filter_code),
    .i_fault_type(i_supply3_fault_type_code),
    .o_over(o_supply3_over),
    .o_under(o_supply3_under),
    .o_fault(o_supply3_fault)
  );

endmodule

// *** hw/sfdc_pkg.sv ***
// Purpose: constants for the supply fault detector configuration block
// Assumes: 125 MHz i_mclk, byte-wide register port behind the serial management port
// Notes: offsets are byte register numbers of the serial register space
package sfdc_pkg;

  // ----------------------------------------
  // register numbers
  // ----------------------------------------
  localparam logic [7:0] SFDC_S2_OVER_TH = 8'h10;
  localparam logic [7:0] SFDC_S2_OVER_HY = 8'h11;
  localparam logic [7:0] SFDC_S2_UNDER_TH = 8'h12;
  localparam logic [7:0] SFDC_S2_UNDER_HY = 8'h13;
  localparam logic [7:0] SFDC_S2_CFG = 8'h14;
  localparam logic [7:0] SFDC_S2_SEL = 8'h15;
  localparam logic [7:0] SFDC_S3_OVER_TH = 8'h18;
  localparam logic [7:0] SFDC_S3_OVER_HY = 8'h19;
  localparam logic [7:0] SFDC_S3_UNDER_TH = 8'h1A;
  localparam logic [7:0] SFDC_S3_UNDER_HY = 8'h1B;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int SFDC_HY_W = 5;
  localparam int SFDC_GF_LSB = 2;
  localparam int SFDC_GF_W = 3;
  localparam int SFDC_FLT_LSB = 0;
  localparam int SFDC_FLT_W = 2;
  localparam int SFDC_SEL_W = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] SFDC_RST_OVER_TH = 8'hFF;
  localparam logic [7:0] SFDC_RST_UNDER_TH = 8'h00;
  localparam logic [4:0] SFDC_RST_HY = 5'h00;
  localparam logic [2:0] SFDC_RST_GF = 3'h0;
  localparam logic [1:0] SFDC_RST_FLT = 2'h3;
  localparam logic [1:0] SFDC_RST_SEL = 2'h0;

  // ----------------------------------------
  // codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SFDC_FLT_OVER = 2'b00,
    SFDC_FLT_EITHER = 2'b01,
    SFDC_FLT_UNDER = 2'b10,
    SFDC_FLT_OFF = 2'b11
  } sfdc_fault_e;

  typedef enum logic [1:0] {
    SFDC_RANGE_MID = 2'b00,
    SFDC_RANGE_LOW = 2'b01,
    SFDC_RANGE_ULTRALOW = 2'b10
  } sfdc_range_e;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SFDC_CLK_MHZ = 125;
  localparam int SFDC_GF_US [8] = '{0, 5, 10, 20, 30, 50, 75, 100};
  localparam int SFDC_CNT_W = 14;
  localparam int SFDC_GF5_CYC = 5 * SFDC_CLK_MHZ;
  localparam int SFDC_GF10_CYC = 10 * SFDC_CLK_MHZ;
  localparam int SFDC_GF20_CYC = 20 * SFDC_CLK_MHZ;
  localparam int SFDC_GF30_CYC = 30 * SFDC_CLK_MHZ;
  localparam int SFDC_GF50_CYC = 50 * SFDC_CLK_MHZ;
  localparam int SFDC_GF75_CYC = 75 * SFDC_CLK_MHZ;
  localparam int SFDC_GF100_CYC = 100 * SFDC_CLK_MHZ;

endpackage

// *** hw/sfdc_detector.sv ***
// Purpose: one supply input: hysteresis comparators, glitch filter, fault select
// Assumes: i_level comes from outside the clock domain
// Notes: fault rises after the filter delay, falls at once
module sfdc_detector #(
  parameter int p_gf50_cycles = sfdc_pkg::SFDC_GF50_CYC,
  parameter int p_gf75_cycles = sfdc_pkg::SFDC_GF75_CYC,
  parameter int p_gf100_cycles = sfdc_pkg::SFDC_GF100_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // measured level code
  input wire logic [7:0] i_level,
  // configuration
  input wire logic [7:0] i_over_th,
  input wire logic [4:0] i_over_hy,
  input wire logic [7:0] i_under_th,
  input wire logic [4:0] i_under_hy,
  input wire logic [2:0] i_gf_code,
  input wire logic [1:0] i_fault_type,
  // results
  output logic o_over,
  output logic o_under,
  output logic o_fault
);
  import sfdc_pkg::*;

  logic [7:0] level_meta;
  logic [7:0] level_sync;
  logic [8:0] over_eff;
  logic [8:0] under_eff;
  logic raw_fault;
  logic [SFDC_CNT_W-1:0] filt_cnt;
  logic [SFDC_CNT_W-1:0] filt_limit;

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      level_meta <= 8'h00;
      level_sync <= 8'h00;
    end else begin
      level_meta <= i_level;
      level_sync <= level_meta;
    end
  end

  // ----------------------------------------
  // effective thresholds, saturating
  // ----------------------------------------
  always_comb begin
    over_eff = {1'b0, i_over_th};
    under_eff = {1'b0, i_under_th};
    if (o_over) begin
      over_eff = {1'b0, i_over_th} - {4'h0, i_over_hy};
      if (over_eff[8]) begin
        over_eff = 9'h000;
      end
    end
    if (o_under) begin
      under_eff = {1'b0, i_under_th} + {4'h0, i_under_hy};
      if (under_eff[8]) begin
        under_eff = 9'h0FF;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_over <= 1'b0;
      o_under <= 1'b0;
    end else begin
      o_over <= {1'b0, level_sync} > over_eff;
      o_under <= {1'b0, level_sync} < under_eff;
    end
  end

  // ----------------------------------------
  // fault select and glitch filter
  // ----------------------------------------
  always_comb begin
    case (i_fault_type)
      SFDC_FLT_OVER: raw_fault = o_over;
      SFDC_FLT_EITHER: raw_fault = o_over | o_under;
      SFDC_FLT_UNDER: raw_fault = o_under;
      default: raw_fault = 1'b0;
    endcase
  end

  always_comb begin
    case (i_gf_code)
      3'h0: filt_limit = SFDC_CNT_W'(0);
      3'h1: filt_limit = SFDC_CNT_W'(SFDC_GF5_CYC);
      3'h2: filt_limit = SFDC_CNT_W'(SFDC_GF10_CYC);
      3'h3: filt_limit = SFDC_CNT_W'(SFDC_GF20_CYC);
      3'h4: filt_limit = SFDC_CNT_W'(SFDC_GF30_CYC);
      3'h5: filt_limit = SFDC_CNT_W'(p_gf50_cycles);
      3'h6: filt_limit = SFDC_CNT_W'(p_gf75_cycles);
      default: filt_limit = SFDC_CNT_W'(p_gf100_cycles);
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      filt_cnt <= '0;
      o_fault <= 1'b0;
    end else if (!raw_fault) begin
      filt_cnt <= '0;
      o_fault <= 1'b0;
    end else if (filt_cnt >= filt_limit) begin
      o_fault <= 1'b1;
    end else begin
      filt_cnt <= filt_cnt + SFDC_CNT_W'(1);
    end
  end

endmodule

// *** test/sfdc_rail_model.sv ***
// Purpose: behavioural supply rails feeding level codes to the detectors
// Assumes: rail levels move at any moment, unrelated to the clock
// Notes: each rail settles 3.3 ns after its request
module sfdc_rail_model (
  // requested levels
  input wire logic [7:0] i_want2,
  input wire logic [7:0] i_want3,
  // rail levels
  output logic [7:0] o_level2,
  output logic [7:0] o_level3
);
  timeunit 1ns;
  timeprecision 100ps;
  // continuous, so the rails carry their starting level from 3.3 ns on
  assign #3.3 o_level2 = i_want2;
  assign #3.3 o_level3 = i_want3;
endmodule

// *** test/sfdc_monitor.sv ***
// Purpose: port checks of sfdc_top
// Assumes: one clock, asynchronous active-high reset
// Notes: attached by the bind below
module sfdc_monitor (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // input three
  input wire logic [1:0] i_supply3_fault_type_code,
  input wire logic [1:0] i_supply3_range_code,
  input wire sfdc_pkg::sfdc_range_e o_supply3_range,
  input wire logic o_supply3_over,
  input wire logic o_supply3_under,
  input wire logic o_supply3_fault
);
  timeunit 1ns;
  timeprecision 100ps;
  import sfdc_pkg::*;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_rd;
    i_reg_rd |=> o_reg_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_hold;
    !i_reg_rd |=> $stable(o_reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_hy;
    o_reg_rvalid && ($past(i_reg_addr[0]) || $past(i_reg_addr) == SFDC_S2_CFG) |-> o_reg_rdata[7:5] == 3'h0;
  endproperty
  a_hy: assert property (p_hy) else $error("unused bits set");
  property p_unm;
    o_reg_rvalid && !($past(i_reg_addr) inside {[8'h10:8'h15], [8'h18:8'h1B]}) |-> o_reg_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_rng;
    o_supply3_range == (i_supply3_range_code[1] ? SFDC_RANGE_ULTRALOW : sfdc_range_e'(i_supply3_range_code));
  endproperty
  a_rng: assert property (p_rng) else $error("range decode");
  property p_off;
    i_supply3_fault_type_code == SFDC_FLT_OFF |=> !o_supply3_fault;
  endproperty
  a_off: assert property (p_off) else $error("fault while off");
  property p_ovo;
    (i_supply3_fault_type_code == SFDC_FLT_OVER && !o_supply3_over) [*3] |-> !o_supply3_fault;
  endproperty
  a_ovo: assert property (p_ovo) else $error("fault without over");
  property p_rise;
    $rose(o_supply3_fault) |-> $past(o_supply3_over || o_supply3_under);
  endproperty
  a_rise: assert property (p_rise) else $error("fault without cause");
endmodule
bind sfdc_top sfdc_monitor mon_u (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_supply3_fault_type_code(i_supply3_fault_type_code),
  .i_supply3_range_code(i_supply3_range_code), .o_supply3_range(o_supply3_range),
  .o_supply3_over(o_supply3_over), .o_supply3_under(o_supply3_under), .o_supply3_fault(o_supply3_fault));

// *** test/supply_fault_detector_config_test.sv ***
// Purpose: self-checking bench of sfdc_top
// Assumes: filter counts shortened to 50, 75 and 100 cycles
// Notes: rails reached through sfdc_rail_model
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module supply_fault_detector_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sfdc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] want [2] = '{8'h60, 8'h60};
  logic [2:0] gf3 = 3'h0;
  logic [1:0] ft3 = 2'h3;
  logic [1:0] rg3 = 2'h0;
  logic [7:0] rdat, lv2, lv3;
  logic rv, ov2, un2, fo2, ov3, un3, fo3;
  sfdc_range_e rn2, rn3;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] ra [10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h1B};
  logic [7:0] rm [10] = '{8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h1F, 8'h03, 8'hFF, 8'h1F, 8'hFF, 8'h1F};
  logic [7:0] rs [10] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
  int lim [8] = '{0, 625, 1250, 2500, 3750, 50, 75, 100};
  always #4 i_mclk = ~i_mclk;
  sfdc_rail_model rail_u (.i_want2(want[0]), .i_want3(want[1]), .o_level2(lv2), .o_level3(lv3));
  sfdc_top #(.p_gf50_cycles(50), .p_gf75_cycles(75), .p_gf100_cycles(100)) dut_u (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_reg_addr(ad), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd),
    .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_second_supply_input(lv2), .i_third_supply_input(lv3),
    .i_supply3_glitch_filter_code(gf3), .i_supply3_fault_type_code(ft3), .i_supply3_range_code(rg3),
    .o_supply2_range(rn2), .o_supply3_range(rn3), .o_supply2_over(ov2), .o_supply2_under(un2),
    .o_supply2_fault(fo2), .o_supply3_over(ov3), .o_supply3_under(un3), .o_supply3_fault(fo3));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic out_of(int s, int k);
    logic [2:0] v;
    v = s ? {fo3, un3, ov3} : {fo2, un2, ov2};
    return v[k];
  endfunction
  function automatic sfdc_range_e exp_rng(logic [1:0] c);
    return c[1] ? SFDC_RANGE_ULTRALOW : sfdc_range_e'(c);
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic idle(int n);
    wr = 1'b0;
    rd = 1'b0;
    tick(n);
  endtask
  // strobes stay up between calls, so accesses run back to back
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    wr = w;
    rd = !w;
    ad = a;
    wd = d;
    tick(1);
    if (!w) begin
      `CHK(rv, 1'b1)
      `CHK(rdat, d)
    end
  endtask
  task automatic cfg(int s, logic [2:0] g, logic [1:0] t);
    if (s == 0) begin
      acc(1'b1, 8'h14, {3'h0, g, t});
    end else begin
      gf3 = g;
      ft3 = t;
    end
    idle(1);
  endtask
  task automatic wait_hi(int s, int k, int bound, output int n);
    n = 0;
    while (out_of(s, k) !== 1'b1 && n < bound) begin
      tick(1);
      n++;
    end
    if (n >= bound) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    int n;
    int hyo;
    int hyu;
    logic so, su;
    logic [7:0] lv, bw;
    logic [7:0] cn [6];
    logic [7:0] v [10];
    void'($urandom(32'hCEBF));
    repeat (12) @(posedge i_mclk);
    #1;
    i_reset = 1'b0;
    for (int i = 0; i < 10; i++) acc(1'b0, ra[i], rs[i]);
    acc(1'b1, 8'h16, 8'hA5);
    acc(1'b0, 8'h16, 8'h00);
    for (int i = 0; i < 10; i++) begin
      v[i] = 8'($urandom());
      acc(1'b1, ra[i], v[i]);
    end
    for (int i = 0; i < 10; i++) acc(1'b0, ra[i], v[i] & rm[i]);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 8'h15, 8'(c));
      rg3 = 2'(c);
      idle(1);
      `CHK(rn2, exp_rng(2'(c)))
      `CHK(rn3, exp_rng(2'(c)))
    end
    for (int s = 0; s < 2; s++) begin
      bw = 8'h10 + 8'(8 * s);
      hyo = $urandom_range(1, 31);
      hyu = $urandom_range(1, 31);
      acc(1'b1, bw, 8'h80);
      acc(1'b1, bw + 8'h01, 8'(hyo));
      acc(1'b1, bw + 8'h02, 8'h40);
      acc(1'b1, bw + 8'h03, 8'(hyu));
      idle(4);
      // band edges first, then random levels around both thresholds
      cn = '{8'h81, 8'(8'h81 - hyo), 8'(8'h80 - hyo), 8'h3F, 8'(8'h3F + hyu), 8'(8'h40 + hyu)};
      so = 1'b0;
      su = 1'b0;
      for (int k = 0; k < 46; k++) begin
        lv = k < 6 ? cn[k] : 8'($urandom_range(8'h30, 8'h90));
        want[s] = lv;
        idle(4);
        so = lv > (so ? 8'(8'h80 - hyo) : 8'h80);
        su = lv < (su ? 8'(8'h40 + hyu) : 8'h40);
        `CHK(out_of(s, 0), so)
        `CHK(out_of(s, 1), su)
      end
      want[s] = 8'h60;
      idle(5);
      for (int g = 0; g < 8; g++) begin
        cfg(s, 3'(g), 2'h0);
        want[s] = 8'hF0;
        wait_hi(s, 0, 8, n);
        wait_hi(s, 2, 4000, n);
        `CHK(n, lim[g] + 1)
        want[s] = 8'h60;
        idle(5);
        `CHK(out_of(s, 2), 1'b0)
      end
      for (int t = 0; t < 4; t++) begin
        cfg(s, 3'h0, 2'(t));
        want[s] = 8'hF0;
        idle(5);
        `CHK(out_of(s, 2), 1'(t < 2))
        want[s] = 8'h20;
        idle(5);
        `CHK(out_of(s, 2), 1'(t == 1 || t == 2))
      end
    end
    complete_run();
  end
endmodule
